// ===== rtl/halt_wake_regs.svh
// Width, timing and idle-priority constants for the halt-mode wake controller.
`ifndef HALT_WAKE_REGS_SVH
`define HALT_WAKE_REGS_SVH
`define HALT_PRIO_W 3
`define HALT_WAKE_CYCLES 1
`define HALT_PRIO_IDLE 3'h7
`endif

// ===== rtl/halt_wake_pkg.sv
// Types shared by the halt-mode wake controller.
package halt_wake_pkg;
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_HALT = 1'b1
    } mode_t;

    typedef struct packed {
        logic nmi;
        logic nmi_nested;
        logic maskable;
        logic [2:0] mask_prio;
    } wake_req_t;

    typedef struct packed {
        logic tmr_sel_sub;
        logic wdt_sel_sub;
        logic watch_sel_div_main;
        logic subclock_used;
    } clk_sel_t;

    typedef struct packed {
        logic core_clk_en;
        logic ack_nmi;
        logic ack_mask;
        logic keep_pending;
        logic tmr_run;
        logic wdt_run;
        logic watch_run;
        logic crc_run;
        logic hold_state;
    } halt_out_t;

    typedef struct packed {
        mode_t mode;
        halt_out_t out;
    } state_t;
endpackage

// ===== rtl/halt_mode_wake_control.sv
// Halt-state entry, wake decision and peripheral run gating.
`timescale 1ns/1ps
`include "halt_wake_regs.svh"

// Function
// RULE_01: Halt entered only by halt instruction in normal operation.
// RULE_02: Halt gates only the core clock; oscillators and peripherals keep running. The code also stops the CRC when its input register was written at entry.
// RULE_03: Halt ends on non-maskable, unmasked maskable request, or any reset.
// RULE_04: Halt with request already pending enters then leaves at once.
// RULE_05: Any qualifying request ends halt regardless of priority.
// RULE_06: Non-maskable wake is acknowledged at release, with interrupts on or off; the code keeps it pending instead when nmi_nested is set.
// RULE_07: Maskable wake with interrupts off stays pending; prior code resumes.
// RULE_08: Enabled, higher-priority handler active: wake stays pending, handler resumes.
// RULE_09: Enabled, lower-priority handler active: wake acknowledged at release.
// RULE_10: Interval timer and watchdog run in halt if subclock used or not selected.
// RULE_11: Watch timer runs in halt with subclock, else only on divided main clock.
// RULE_12: CRC runs in halt unless its input register was being written at entry.
// RULE_13: Port outputs and core registers hold their values throughout halt.
// RULE_14: Core clock restarts the cycle after release, with no stabilisation wait.
module halt_mode_wake_control (
    input wire logic core_clk, // Main clock.
    input wire logic rst_n, // Synchronous reset, all system sources combined.
    input wire logic halt_exec, // Pulse: core executes the halt instruction.
    input wire logic normal_mode, // Core is in normal operation mode.
    input wire logic ints_enabled, // Level: interrupts globally enabled.
    input wire logic [`HALT_PRIO_W-1:0] active_prio, // Priority of handler in service.
    input wire logic crc_in_write, // CRC input register written this cycle.
    input wire halt_wake_pkg::wake_req_t wake_req, // Wake requests from controller.
    input wire halt_wake_pkg::clk_sel_t clk_sel, // Count clock choices.
    output halt_wake_pkg::halt_out_t ctl, // Registered control outputs.
    output logic halted // Level: halt state active.
);
    halt_wake_pkg::state_t state_reg;
    halt_wake_pkg::state_t state_next;
    logic crc_blocked_reg;
    logic crc_blocked_next;
    logic wake;
    logic ack_ok;

    // The acknowledge and pending pulses last exactly one cycle after release.
    // The interrupt controller must latch them then, since nothing is held here.
    // Run flags are computed every cycle so peripherals never see a gap at entry.
    // A CRC write that coincides with entry blocks the CRC until the next release,
    // because its input data would otherwise be lost while the core clock is off.

    // Lower numbers are higher priority; a handler at the idle code means none active.
    function automatic logic waker_wins(input logic [`HALT_PRIO_W-1:0] req,
                                        input logic [`HALT_PRIO_W-1:0] act);
        waker_wins = req < act;
    endfunction

    always_comb begin
        // Priority is not consulted here, so any request ends halt.
        wake = wake_req.nmi | wake_req.maskable; // [RULE_03] [RULE_05]
        ack_ok = ints_enabled && waker_wins(wake_req.mask_prio, active_prio); // [RULE_09]
    end

    always_comb begin
        state_next = state_reg;
        crc_blocked_next = crc_blocked_reg;
        state_next.out.ack_nmi = 1'b0;
        state_next.out.ack_mask = 1'b0;
        state_next.out.keep_pending = 1'b0;
        unique case (state_reg.mode)
            halt_wake_pkg::ST_RUN: begin
                state_next.out.core_clk_en = 1'b1;
                state_next.out.hold_state = 1'b0;
                if (halt_exec && normal_mode) begin // [RULE_01]
                    // A pending request still enters halt; release follows next cycle.
                    state_next.mode = halt_wake_pkg::ST_HALT; // [RULE_04]
                    state_next.out.core_clk_en = 1'b0; // [RULE_02]
                    state_next.out.hold_state = 1'b1; // [RULE_13]
                    crc_blocked_next = crc_in_write; // [RULE_12]
                end
            end
            halt_wake_pkg::ST_HALT: begin
                if (wake) begin
                    state_next.mode = halt_wake_pkg::ST_RUN;
                    state_next.out.core_clk_en = 1'b1; // [RULE_14]
                    state_next.out.hold_state = 1'b0;
                    crc_blocked_next = 1'b0;
                    if (wake_req.nmi && !wake_req.nmi_nested) begin
                        state_next.out.ack_nmi = 1'b1; // [RULE_06]
                    end else if (wake_req.maskable && ack_ok) begin
                        state_next.out.ack_mask = 1'b1; // [RULE_09]
                    end else begin
                        state_next.out.keep_pending = 1'b1; // [RULE_07] [RULE_08]
                    end
                end
            end
        endcase
        state_next.out.tmr_run = clk_sel.subclock_used | ~clk_sel.tmr_sel_sub; // [RULE_10]
        state_next.out.wdt_run = clk_sel.subclock_used | ~clk_sel.wdt_sel_sub; // [RULE_10]
        state_next.out.watch_run = clk_sel.subclock_used |
                                   clk_sel.watch_sel_div_main; // [RULE_11]
        state_next.out.crc_run = ~crc_blocked_next; // [RULE_12]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= '{mode: halt_wake_pkg::ST_RUN,
                           out: '{core_clk_en: 1'b1, tmr_run: 1'b1, wdt_run: 1'b1,
                                  watch_run: 1'b1, crc_run: 1'b1, default: 1'b0}};
            crc_blocked_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            crc_blocked_reg <= crc_blocked_next;
        end
    end

    assign ctl = state_reg.out;
    assign halted = (state_reg.mode == halt_wake_pkg::ST_HALT);
endmodule

// ===== test/halt_chk_checker.sv
// Port checks for the halt wake controller.
`timescale 1ns/1ps
module halt_chk (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset
    input wire logic halt_exec, // halt pulse
    input wire logic normal_mode, // mode
    input wire logic ints_enabled, // enable
    input wire logic [2:0] active_prio, // handler level
    input wire halt_wake_pkg::wake_req_t wake_req, // wakes
    input wire halt_wake_pkg::halt_out_t ctl, // controls
    input wire logic halted // state
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // A maskable wake only counts when no non-maskable request competes.
    wire w = halted && !wake_req.nmi && wake_req.maskable;
    entry_ok_a: assert property (!halted && halt_exec && normal_mode |=> halted)
        else $error("no entry");
    entry_no_a: assert property (!halted && !(halt_exec && normal_mode) |=> !halted)
        else $error("bad entry");
    core_gate_a: assert property (ctl.core_clk_en != halted) else $error("gate");
    nmi_wake_a: assert property (halted && wake_req.nmi && !wake_req.nmi_nested
        |=> !halted && ctl.ack_nmi) else $error("nmi");
    mask_off_a: assert property (w && !ints_enabled
        |=> ctl.keep_pending && !ctl.ack_mask) else $error("mask off");
    mask_ack_a: assert property (w && ints_enabled && wake_req.mask_prio < active_prio
        |=> ctl.ack_mask && !halted) else $error("mask ack");
    mask_keep_a: assert property (w && ints_enabled && wake_req.mask_prio >= active_prio
        |=> ctl.keep_pending && !halted) else $error("mask keep");
    hold_port_a: assert property (halted |-> ctl.hold_state) else $error("hold");
endmodule
bind halt_mode_wake_control halt_chk i_chk (.core_clk, .rst_n, .halt_exec, .normal_mode,
    .ints_enabled, .active_prio, .wake_req, .ctl, .halted);

// ===== test/wake_src.sv
// Interrupt controller model driving wake requests.
`timescale 1ns/1ps
module wake_src (
    input wire logic core_clk, // clock
    input wire logic rst_n, // reset
    input wire halt_wake_pkg::wake_req_t req, // requested wake
    output halt_wake_pkg::wake_req_t wake_req // to controller
);
    // Registered, so a wake lands a cycle late as from a flopped controller.
    always_ff @(posedge core_clk) begin
        wake_req <= rst_n ? req : '0;
    end
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the halt wake controller.
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 0, rst_n = 0, halt_exec = 0, normal_mode = 1, ints_enabled = 0;
    logic crc_in_write = 0;
    logic [2:0] active_prio = 3'h7;
    halt_wake_pkg::wake_req_t req = '0, wake_req;
    halt_wake_pkg::clk_sel_t clk_sel = '0;
    halt_wake_pkg::halt_out_t ctl;
    logic halted;
    int mismatches = 0, checked = 0;
    always #4 core_clk = ~core_clk;
    wake_src i_src (.core_clk, .rst_n, .req, .wake_req);
    halt_mode_wake_control i_dut (.core_clk, .rst_n, .halt_exec, .normal_mode, .ints_enabled,
        .active_prio, .crc_in_write, .wake_req, .clk_sel, .ctl, .halted);
    task chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task refuse;
        normal_mode <= 0;
        halt_exec <= 1;
        @(posedge core_clk);
        halt_exec <= 0;
        normal_mode <= 1;
        #1 chk({1'b0, halted, ctl.core_clk_en, ctl.hold_state}, 4'h2);
        $display("refuse done");
        @(posedge core_clk);
    endtask
    task flags(input halt_wake_pkg::clk_sel_t sel, input logic [3:0] exp);
        clk_sel <= sel;
        repeat (2) @(posedge core_clk);
        #1 chk({ctl.tmr_run, ctl.wdt_run, ctl.watch_run, ctl.crc_run}, exp);
        $display("flags done %h", exp);
    endtask
    task crc_halt;
        crc_in_write <= 1;
        halt_exec <= 1;
        @(posedge core_clk);
        crc_in_write <= 0;
        halt_exec <= 0;
        #1 chk({1'b0, halted, ctl.crc_run, ctl.hold_state}, 4'h5);
        req <= 6'h20;
        for (int i = 0; i < 4 && halted; i++) @(posedge core_clk) #1;
        chk({1'b0, halted, ctl.crc_run, ctl.ack_nmi}, 4'h3);
        req <= '0;
        $display("crc done");
        @(posedge core_clk);
    endtask
    task wake(input logic pre, input halt_wake_pkg::wake_req_t r, input logic ien,
        input logic [2:0] act, input logic [2:0] exp);
        ints_enabled <= ien;
        active_prio <= act;
        req <= pre ? r : '0;
        @(posedge core_clk);
        halt_exec <= 1;
        @(posedge core_clk);
        halt_exec <= 0;
        req <= r;
        #1 chk({1'b0, halted, ctl.core_clk_en, ctl.hold_state}, 4'h5);
        for (int i = 0; i < 4 && halted; i++) @(posedge core_clk) #1;
        chk({halted, ctl.ack_nmi, ctl.ack_mask, ctl.keep_pending}, {1'b0, exp});
        $display("wake done %h", exp);
        @(posedge core_clk);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        refuse;
        flags(4'hE, 4'h3);
        flags(4'hD, 4'hF);
        flags(4'h0, 4'hD);
        crc_halt;
        wake(0, 6'h20, 0, 3'h7, 3'h4);
        wake(0, 6'h20, 1, 3'h2, 3'h4);
        wake(0, 6'h30, 1, 3'h7, 3'h1);
        wake(0, 6'h0B, 0, 3'h7, 3'h1);
        wake(0, 6'h0B, 1, 3'h1, 3'h1);
        wake(0, 6'h0B, 1, 3'h7, 3'h2);
        wake(1, 6'h0B, 1, 3'h4, 3'h2);
        end_sim;
    end
    initial begin
        #20000;
        mismatches++;
        end_sim;
    end
endmodule
